// file: verilog/spi_pkg.sv
// shared constants and types of the serial port init and pin timing block
package spi_pkg;
	localparam int DATA_BITS = 8;
	localparam int DIV_BITS = 16;
	localparam logic [15:0] DIV_MIN = 16'h0002;
	localparam logic [15:0] DIV_MIN_1X = 16'h0008;
	localparam logic [15:0] DIV_RESET = 16'h0000;
	localparam logic [5:0] HALVES_PER_BIT_16X = 6'h20;
	localparam logic [5:0] HALVES_PER_BIT_1X = 6'h02;
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [3:0] FIRST_BIT = 4'h0;
	localparam logic [1:0] SEL_OFF = 2'h0;
	localparam logic [1:0] SEL_BRG = 2'h1;
	localparam logic [1:0] SEL_EXPANSION = 2'h3;

	typedef struct packed {
		logic sync_mode_enable;
		logic clock_source_sel_hi;
		logic clock_source_sel_lo;
		logic clock_divide_bypass;
		logic ext_receive_clock_enable;
		logic ext_transmit_clock_enable;
		logic carrier_active_level;
		logic clock_idle_level;
		logic clock_active_rising;
		logic rts_active_level;
	} spi_cfg_type;

	typedef struct packed {
		logic serial_out_pin;
		logic serial_clock_output;
		logic rts_out;
		logic first_bit_strobe_out;
	} spi_pins_type;

	typedef enum logic [3:0] {
		TX_IDLE = 4'h1,
		TX_START = 4'h2,
		TX_DATA = 4'h4,
		TX_STOP = 4'h8
	} spi_tx_state_type;
endpackage

// file: verilog/spi_buffer.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module spi_buffer #(
	parameter int WIDTH = 8
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire logic i_flush,
	input wire logic i_in_valid,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_in_ready,
	output logic o_out_valid,
	output logic [WIDTH-1:0] o_out_data,
	input wire logic i_out_ready
);
	logic [WIDTH-1:0] mem [2];
	logic wr_ptr;
	logic rd_ptr;
	logic [1:0] count;
	logic in_ready;
	logic next_wr_ptr;
	logic next_rd_ptr;
	logic [1:0] next_count;
	logic push;
	logic pop;

	always_comb begin
		push = i_in_valid && in_ready;
		pop = (count != 2'h0) && i_out_ready;
		next_wr_ptr = wr_ptr ^ push;
		next_rd_ptr = rd_ptr ^ pop;
		next_count = count + {1'b0, push} - {1'b0, pop};
		if (i_flush) begin
			next_wr_ptr = 1'b0;
			next_rd_ptr = 1'b0;
			next_count = 2'h0;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count <= 2'h0;
			in_ready <= 1'b0;
		end else if (i_ce) begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
			in_ready <= (next_count != 2'h2);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_ce && push && !i_flush) begin
			mem[wr_ptr] <= i_in_data;
		end
	end

	assign o_in_ready = in_ready;
	assign o_out_valid = (count != 2'h0);
	assign o_out_data = mem[rd_ptr];
endmodule
`default_nettype wire

// file: verilog/spi_serial_port.sv
// serial port initialisation sequence, clock generation and pin timing
`timescale 1ns/1ps
`default_nettype none
module spi_serial_port #(
	parameter int DATA_W = spi_pkg::DATA_BITS,
	parameter int DIV_W = spi_pkg::DIV_BITS
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire logic i_div_hi_wr,
	input wire logic i_div_lo_wr,
	input wire logic [7:0] i_div_byte,
	input wire spi_pkg::spi_cfg_type i_cfg,
	input wire logic i_tx_valid,
	input wire logic [DATA_W-1:0] i_tx_data,
	output logic o_tx_ready,
	output logic o_rx_valid,
	output logic [DATA_W-1:0] o_rx_data,
	output logic o_enabled,
	input wire logic i_serial_in_pin,
	input wire logic i_ext_receive_clock_in,
	input wire logic i_ext_transmit_clock_in,
	input wire logic i_carrier_detect_gate,
	output spi_pkg::spi_pins_type o_pins
);
	function automatic logic [15:0] eff_divisor(input logic [15:0] div, input logic one_x);
		eff_divisor = (one_x && div < spi_pkg::DIV_MIN_1X) ? spi_pkg::DIV_MIN_1X : div;
	endfunction

	function automatic logic edge_of(input logic now, input logic was, input logic rising);
		edge_of = rising ? (now && !was) : (!now && was);
	endfunction

	// divisor bytes and enable sequence
	logic [7:0] div_hi;
	logic [7:0] div_lo;
	logic pend_hi;
	logic pend_lo;
	logic enabled;
	logic [7:0] next_div_hi;
	logic [7:0] next_div_lo;
	logic next_pend_hi;
	logic next_pend_lo;
	logic next_enabled;
	logic any_wr;

	always_comb begin
		next_div_hi = div_hi;
		next_div_lo = div_lo;
		next_pend_hi = pend_hi;
		next_pend_lo = pend_lo;
		next_enabled = enabled;
		any_wr = i_div_hi_wr || i_div_lo_wr;
		if (i_div_hi_wr) begin
			next_div_hi = i_div_byte;
			next_pend_hi = 1'b1;
		end
		if (i_div_lo_wr) begin
			next_div_lo = i_div_byte;
			next_pend_lo = 1'b1;
		end
		if (any_wr) begin
			next_enabled = 1'b0;
			if (next_pend_hi && next_pend_lo) begin
				next_enabled = 1'b1;
				next_pend_hi = 1'b0;
				next_pend_lo = 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			div_hi <= spi_pkg::DIV_RESET[15:8];
			div_lo <= spi_pkg::DIV_RESET[7:0];
			pend_hi <= 1'b0;
			pend_lo <= 1'b0;
			enabled <= 1'b0;
		end else if (i_ce) begin
			div_hi <= next_div_hi;
			div_lo <= next_div_lo;
			pend_hi <= next_pend_hi;
			pend_lo <= next_pend_lo;
			enabled <= next_enabled;
		end
	end

	// two-stage synchronisers, third stage for edges
	logic [1:0] rxc_sync;
	logic [1:0] txc_sync;
	logic [1:0] dcd_sync;
	logic [1:0] sin_sync;
	logic rxc_d;
	logic txc_d;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rxc_sync <= 2'h0;
			txc_sync <= 2'h0;
			dcd_sync <= 2'h0;
			sin_sync <= 2'h3;
			rxc_d <= 1'b0;
			txc_d <= 1'b0;
		end else if (i_ce) begin
			rxc_sync <= {rxc_sync[0], i_ext_receive_clock_in};
			txc_sync <= {txc_sync[0], i_ext_transmit_clock_in};
			dcd_sync <= {dcd_sync[0], i_carrier_detect_gate};
			sin_sync <= {sin_sync[0], i_serial_in_pin};
			rxc_d <= rxc_sync[1];
			txc_d <= txc_sync[1];
		end
	end

	// baud rate generator
	logic [DIV_W-1:0] brg_cnt;
	logic brg_out;
	logic [DIV_W-1:0] next_brg_cnt;
	logic next_brg_out;
	logic [15:0] div_eff;
	logic brg_in;
	logic brg_rise;
	logic brg_fall;
	logic half_tick;

	always_comb begin
		// 1x internal shift clock kept at or below internal/8
		div_eff = eff_divisor({div_hi, div_lo}, i_cfg.clock_divide_bypass);
		brg_in = i_cfg.ext_receive_clock_enable ? edge_of(rxc_sync[1], rxc_d, 1'b1) : 1'b1;
		brg_rise = 1'b0;
		brg_fall = 1'b0;
		next_brg_cnt = brg_cnt;
		next_brg_out = brg_out;
		if (!enabled) begin
			// counter held at zero until the divisor pair is loaded
			next_brg_cnt = '0;
			next_brg_out = 1'b1;
		// divisor of 0 or 1 stops the generator when clock_divide_bypass is clear
		end else if (brg_in && div_eff >= spi_pkg::DIV_MIN) begin
			if (brg_cnt == DIV_W'(div_eff - 16'h0001)) begin
				next_brg_cnt = '0;
				next_brg_out = 1'b1;
				brg_rise = 1'b1;
			end else begin
				next_brg_cnt = brg_cnt + 1'b1;
				if (next_brg_cnt == DIV_W'(div_eff >> 1)) begin
					next_brg_out = 1'b0;
					brg_fall = 1'b1;
				end
			end
		end
		half_tick = i_cfg.ext_transmit_clock_enable
			? (txc_sync[1] != txc_d) : (brg_rise || brg_fall);
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			brg_cnt <= '0;
			brg_out <= 1'b1;
		end else if (i_ce) begin
			brg_cnt <= next_brg_cnt;
			brg_out <= next_brg_out;
		end
	end

	// transmit data buffer
	logic buf_valid;
	logic [DATA_W-1:0] buf_data;
	logic pop;

	spi_buffer #(
		.WIDTH(DATA_W)
	) u_tx_buffer (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_ce(i_ce),
		.i_flush(any_wr),
		.i_in_valid(i_tx_valid),
		.i_in_data(i_tx_data),
		.o_in_ready(o_tx_ready),
		.o_out_valid(buf_valid),
		.o_out_data(buf_data),
		.i_out_ready(pop)
	);

	// transmitter
	spi_pkg::spi_tx_state_type state;
	spi_pkg::spi_tx_state_type next_state;
	logic [DATA_W-1:0] tx_sh;
	logic [3:0] bit_n;
	logic [5:0] half_cnt;
	logic [DATA_W-1:0] next_tx_sh;
	logic [3:0] next_bit_n;
	logic [5:0] next_half_cnt;
	logic [5:0] halves;
	logic bit_end;
	logic second_half;
	logic sync_mode;
	logic [1:0] sel;

	always_comb begin
		sync_mode = i_cfg.sync_mode_enable;
		sel = {i_cfg.clock_source_sel_hi, i_cfg.clock_source_sel_lo};
		// sixteen-times division in either mode unless clock_divide_bypass is set
		halves = i_cfg.clock_divide_bypass
			? spi_pkg::HALVES_PER_BIT_1X : spi_pkg::HALVES_PER_BIT_16X;
		bit_end = half_tick && (half_cnt == halves - 6'h01);
		second_half = (half_cnt >= (halves >> 1));
		pop = enabled && (state == spi_pkg::TX_IDLE) && buf_valid;
		next_state = state;
		next_tx_sh = tx_sh;
		next_bit_n = bit_n;
		next_half_cnt = half_cnt;
		if (state != spi_pkg::TX_IDLE && half_tick) begin
			next_half_cnt = bit_end ? 6'h00 : half_cnt + 6'h01;
		end
		case (state)
			spi_pkg::TX_IDLE: begin
				if (pop) begin
					next_tx_sh = buf_data;
					next_bit_n = spi_pkg::FIRST_BIT;
					next_half_cnt = 6'h00;
					next_state = sync_mode ? spi_pkg::TX_DATA : spi_pkg::TX_START;
				end
			end
			spi_pkg::TX_START: begin
				if (bit_end) begin
					next_state = spi_pkg::TX_DATA;
				end
			end
			spi_pkg::TX_DATA: begin
				if (bit_end) begin
					next_tx_sh = tx_sh >> 1;
					next_bit_n = bit_n + 4'h1;
					if (bit_n == spi_pkg::LAST_BIT) begin
						next_state = sync_mode ? spi_pkg::TX_IDLE : spi_pkg::TX_STOP;
					end
				end
			end
			spi_pkg::TX_STOP: begin
				if (bit_end) begin
					next_state = spi_pkg::TX_IDLE;
				end
			end
			default: begin
				next_state = spi_pkg::TX_IDLE;
			end
		endcase
		if (!enabled || any_wr) begin
			next_state = spi_pkg::TX_IDLE;
			next_half_cnt = 6'h00;
			next_bit_n = spi_pkg::FIRST_BIT;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state <= spi_pkg::TX_IDLE;
			tx_sh <= '0;
			bit_n <= spi_pkg::FIRST_BIT;
			half_cnt <= 6'h00;
		end else if (i_ce) begin
			state <= next_state;
			tx_sh <= next_tx_sh;
			bit_n <= next_bit_n;
			half_cnt <= next_half_cnt;
		end
	end

	// pin drivers
	spi_pkg::spi_pins_type pins;
	spi_pkg::spi_pins_type next_pins;
	logic in_data;
	logic exp_clk;
	logic sync_clk;
	logic rts_on;

	always_comb begin
		in_data = (state == spi_pkg::TX_DATA);
		// expansion clock low then rising mid-bit, idle high
		exp_clk = in_data ? second_half : 1'b1;
		// synchronous clock idle level and active edge programmable
		sync_clk = in_data
			? (second_half ? i_cfg.clock_active_rising : !i_cfg.clock_active_rising)
			: i_cfg.clock_idle_level;
		// serial data out in every mode
		next_pins.serial_out_pin = (state == spi_pkg::TX_START) ? 1'b0
			: (in_data ? tx_sh[0] : 1'b1);
		if (sync_mode) begin
			// code 00 turns the clock output off
			next_pins.serial_clock_output = (sel == spi_pkg::SEL_OFF)
				? i_cfg.clock_idle_level : sync_clk;
		end else begin
			// code 11 picks serial expansion mode
			case (sel)
				spi_pkg::SEL_EXPANSION: next_pins.serial_clock_output = exp_clk;
				spi_pkg::SEL_BRG: next_pins.serial_clock_output = brg_out;
				default: next_pins.serial_clock_output = 1'b1;
			endcase
		end
		// active from first bit until the last active edge, dropping in the same cycle
		rts_on = sync_mode && in_data && !(bit_n == spi_pkg::LAST_BIT && second_half);
		next_pins.rts_out = rts_on ? i_cfg.rts_active_level : !i_cfg.rts_active_level;
		// strobe high for the first bit only
		next_pins.first_bit_strobe_out = sync_mode && in_data && (bit_n == spi_pkg::FIRST_BIT);
		// idle levels while held in reset
		if (!enabled) begin
			next_pins.serial_out_pin = 1'b1;
			next_pins.serial_clock_output = sync_mode ? i_cfg.clock_idle_level : 1'b1;
			next_pins.rts_out = !i_cfg.rts_active_level;
			next_pins.first_bit_strobe_out = 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pins <= '{serial_out_pin: 1'b1, serial_clock_output: 1'b1,
				rts_out: 1'b1, first_bit_strobe_out: 1'b0};
		end else if (i_ce) begin
			pins <= next_pins;
		end
	end

	// synchronous receiver
	logic [DATA_W-1:0] rx_sh;
	logic [3:0] rx_n;
	logic rx_valid;
	logic [DATA_W-1:0] rx_data;
	logic [DATA_W-1:0] next_rx_sh;
	logic [3:0] next_rx_n;
	logic next_rx_valid;
	logic [DATA_W-1:0] next_rx_data;
	logic rx_edge;

	always_comb begin
		// carrier detect gates the receive clock, sync mode only
		rx_edge = enabled && sync_mode && (dcd_sync[1] == i_cfg.carrier_active_level)
			&& edge_of(rxc_sync[1], rxc_d, i_cfg.clock_active_rising);
		next_rx_sh = rx_sh;
		next_rx_n = rx_n;
		next_rx_valid = 1'b0;
		next_rx_data = rx_data;
		if (rx_edge) begin
			next_rx_sh = {sin_sync[1], rx_sh[DATA_W-1:1]};
			next_rx_n = rx_n + 4'h1;
			if (rx_n == spi_pkg::LAST_BIT) begin
				next_rx_n = spi_pkg::FIRST_BIT;
				next_rx_valid = 1'b1;
				next_rx_data = next_rx_sh;
			end
		end
		if (!enabled || any_wr) begin
			next_rx_n = spi_pkg::FIRST_BIT;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rx_sh <= '0;
			rx_n <= spi_pkg::FIRST_BIT;
			rx_valid <= 1'b0;
			rx_data <= '0;
		end else if (i_ce) begin
			rx_sh <= next_rx_sh;
			rx_n <= next_rx_n;
			rx_valid <= next_rx_valid;
			rx_data <= next_rx_data;
		end
	end

	assign o_pins = pins;
	assign o_rx_valid = rx_valid;
	assign o_rx_data = rx_data;
	assign o_enabled = enabled;
endmodule
`default_nettype wire

// file: bench/spi_serial_port_assertions.sv
// concurrent checks on the serial port top ports
`timescale 1ns/1ps
`default_nettype none
module spi_serial_port_chk (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire logic i_div_hi_wr,
	input wire logic i_div_lo_wr,
	input wire spi_pkg::spi_cfg_type i_cfg,
	input wire logic o_rx_valid,
	input wire logic o_enabled,
	input wire spi_pkg::spi_pins_type o_pins
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	logic hi_only, lo_only, sync, rts_act;
	assign hi_only = i_ce && i_div_hi_wr && !i_div_lo_wr;
	assign lo_only = i_ce && i_div_lo_wr && !i_div_hi_wr;
	assign sync = i_cfg.sync_mode_enable;
	assign rts_act = o_pins.rts_out == i_cfg.rts_active_level;
	hi_stop_a: assert property (hi_only && o_enabled |=> !o_enabled)
		else $error("still enabled after high byte write");
	lo_stop_a: assert property (lo_only && o_enabled |=> !o_enabled)
		else $error("still enabled after low byte write");
	pair_start_a: assert property (hi_only ##3 lo_only |=> o_enabled)
		else $error("not enabled after byte pair");
	reset_idle_a: assert property (!o_enabled && !$past(o_enabled) |->
		o_pins.serial_out_pin && !o_pins.first_bit_strobe_out)
		else $error("outputs not idle while disabled");
	strobe_sync_a: assert property (o_pins.first_bit_strobe_out |-> sync)
		else $error("strobe outside sync mode");
	rts_async_a: assert property (o_enabled && !sync |-> !rts_act)
		else $error("request active outside sync mode");
	fixed_high_a: assert property (o_enabled && !sync && !i_cfg.clock_source_sel_lo
		|-> o_pins.serial_clock_output)
		else $error("clock output not held high");
	clock_off_a: assert property (o_enabled && sync && !i_cfg.clock_source_sel_hi
		&& !i_cfg.clock_source_sel_lo |-> o_pins.serial_clock_output == i_cfg.clock_idle_level)
		else $error("disabled clock output moved");
	rts_start_a: assert property (o_enabled && sync && !$stable(o_pins.rts_out)
		&& rts_act |-> o_pins.first_bit_strobe_out)
		else $error("request raised without first bit strobe");
	strobe_end_a: assert property ($fell(o_pins.first_bit_strobe_out) && o_enabled
		|-> rts_act)
		else $error("strobe fell outside frame");
	rx_sync_a: assert property (o_rx_valid |-> sync)
		else $error("word received outside sync mode");
	cover property ($rose(o_enabled));
	cover property (o_rx_valid);
	cover property ($rose(o_pins.first_bit_strobe_out));
endmodule
bind spi_serial_port spi_serial_port_chk i_chk (.i_clk, .i_rstn, .i_ce, .i_div_hi_wr,
	.i_div_lo_wr, .i_cfg, .o_rx_valid, .o_enabled, .o_pins);
`default_nettype wire

// file: bench/spi_remote_model.sv
// remote partner: sends sync frames, captures bits on clock output rises
`timescale 1ns/1ps
`default_nettype none
module spi_remote_model (
	input wire logic i_clk,
	input wire spi_pkg::spi_pins_type i_pins,
	output logic o_data,
	output logic o_rclk,
	output logic o_carrier,
	output logic [7:0] o_word,
	output int o_bits
);
	logic last_clk;
	initial begin
		o_data = 1'b1;
		o_rclk = 1'b0;
		o_carrier = 1'b0;
		o_word = 8'h00;
		o_bits = 0;
		last_clk = 1'b1;
	end
	always @(posedge i_clk) begin
		if (!last_clk && i_pins.serial_clock_output) begin
			o_word <= {i_pins.serial_out_pin, o_word[7:1]};
			o_bits <= o_bits + 1;
		end
		last_clk <= i_pins.serial_clock_output;
	end
	task automatic send(input logic [7:0] w, input logic act);
		o_carrier = act;
		repeat (2) @(negedge i_clk);
		for (int i = 0; i < 8; i++) begin
			o_data = w[i];
			repeat (4) @(negedge i_clk);
			o_rclk = 1'b1;
			repeat (4) @(negedge i_clk);
			o_rclk = 1'b0;
		end
		o_carrier = 1'b0;
		o_data = ~w[7];
	endtask
endmodule
`default_nettype wire

// file: bench/spi_serial_port_tb_top.sv
// self-checking bench of the serial port block
`timescale 1ns/1ps
`default_nettype none
module spi_serial_port_tb_top;
	logic i_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic hi_wr = 1'b0;
	logic lo_wr = 1'b0;
	logic [7:0] div_byte = 8'h00;
	spi_pkg::spi_cfg_type cfg = 10'h000;
	logic tx_valid = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic tclk = 1'b0;
	logic tx_ready, rx_valid, enabled, sdata, rclk, carrier;
	logic [7:0] rx_data, cap_word;
	int cap_bits;
	spi_pkg::spi_pins_type pins;
	int fails = 0;
	int total_checks = 0;
	always #50 i_clk = ~i_clk;
	spi_serial_port i_spi_serial_port (.i_clk, .i_rstn, .i_ce(1'b1), .i_div_hi_wr(hi_wr),
		.i_div_lo_wr(lo_wr), .i_div_byte(div_byte), .i_cfg(cfg), .i_tx_valid(tx_valid),
		.i_tx_data(tx_data), .o_tx_ready(tx_ready), .o_rx_valid(rx_valid),
		.o_rx_data(rx_data), .o_enabled(enabled), .i_serial_in_pin(sdata),
		.i_ext_receive_clock_in(rclk), .i_ext_transmit_clock_in(tclk),
		.i_carrier_detect_gate(carrier), .o_pins(pins));
	spi_remote_model i_spi_remote_model (.i_clk, .i_pins(pins), .o_data(sdata),
		.o_rclk(rclk), .o_carrier(carrier), .o_word(cap_word), .o_bits(cap_bits));
	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wait_bits(input int n);
		for (int i = 0; i < 400 && cap_bits < n; i++)
			@(negedge i_clk);
		if (cap_bits < n) begin
			fails++;
			summarize();
		end
	endtask
	task automatic wr(input logic hi, input logic [7:0] b);
		div_byte = b;
		hi_wr = hi;
		lo_wr = !hi;
		@(negedge i_clk);
		hi_wr = 1'b0;
		lo_wr = 1'b0;
	endtask
	task automatic init(input logic [9:0] c);
		wr(1'b1, 8'h00);
		cmp(8'(enabled), 8'h00);
		@(negedge i_clk);
		// config only while held in reset
		cfg = c;
		@(negedge i_clk);
		wr(1'b0, 8'h08);
		cmp(8'(enabled), 8'h01);
	endtask
	task automatic send_word(input logic [7:0] d);
		tx_data = d;
		tx_valid = 1'b1;
		for (int i = 0; i < 50 && !tx_ready; i++)
			@(negedge i_clk);
		if (!tx_ready) begin
			fails++;
			summarize();
		end
		@(negedge i_clk);
		tx_valid = 1'b0;
	endtask
	task automatic t_baud_out;
		int base;
		init(10'h08F);
		wait_bits(cap_bits + 1);
		base = cap_bits;
		repeat (64) @(negedge i_clk);
		cmp(8'(cap_bits - base), 8'h08);
	endtask
	task automatic t_ext_clock;
		int base;
		init(10'h2DB);
		base = cap_bits;
		send_word(8'h4D);
		// external clock at internal over eight
		for (int i = 0; i < 20; i++) begin
			repeat (4) @(negedge i_clk);
			tclk = ~tclk;
		end
		cmp(cap_word, 8'h4D);
		repeat (20) @(negedge i_clk);
		cmp(8'(cap_bits - base), 8'h08);
	endtask
	task automatic t_expansion;
		int base;
		init(10'h1CF);
		base = cap_bits;
		send_word(8'h5A);
		wait_bits(base + 8);
		cmp(cap_word, 8'h5A);
		repeat (40) @(negedge i_clk);
		cmp(8'(cap_bits - base), 8'h08);
	endtask
	task automatic t_sync_burst;
		int base, acc;
		logic [7:0] w [4];
		w = '{8'hA5, 8'h3C, 8'h81, 8'hFF};
		acc = 0;
		init(10'h2CB);
		base = cap_bits;
		tx_valid = 1'b1;
		for (int i = 0; i < 400 && acc < 4; i++) begin
			tx_data = w[acc];
			if (i == 6)
				cmp(8'(acc), 8'h03);
			if (tx_ready)
				acc++;
			@(negedge i_clk);
		end
		tx_valid = 1'b0;
		if (acc < 4) begin
			fails++;
			summarize();
		end
		for (int k = 0; k < 4; k++) begin
			wait_bits(base + 8 * (k + 1));
			cmp(cap_word, w[k]);
		end
	endtask
	task automatic t_receive(input logic [9:0] c, input logic act, input logic vld);
		int got;
		got = 0;
		init(c);
		fork
			i_spi_remote_model.send(8'h96, act);
			for (int i = 0; i < 120; i++) begin
				@(negedge i_clk);
				if (rx_valid === 1'b1)
					got++;
			end
		join
		cmp(8'(got), 8'(vld));
		if (vld)
			cmp(rx_data, 8'h96);
	endtask
	task automatic t_abort;
		int base;
		init(10'h2CB);
		base = cap_bits;
		send_word(8'hC3);
		wait_bits(base + 3);
		wr(1'b1, 8'h00);
		cmp(8'(enabled), 8'h00);
		base = cap_bits;
		repeat (4) @(negedge i_clk);
		cmp(8'(pins), 8'h08);
		wr(1'b0, 8'h08);
		repeat (80) @(negedge i_clk);
		cmp(8'(cap_bits - base), 8'h00);
	endtask
	initial begin
		repeat (5) @(negedge i_clk);
		cmp(8'(pins), 8'h0E);
		cmp(8'(tx_ready), 8'h00);
		i_rstn = 1'b1;
		@(negedge i_clk);
		t_expansion();
		t_baud_out();
		t_sync_burst();
		t_ext_clock();
		t_receive(10'h24B, 1'b1, 1'b1);
		t_receive(10'h24B, 1'b0, 1'b0);
		t_receive(10'h04B, 1'b1, 1'b0);
		t_abort();
		summarize();
	end
endmodule
`default_nettype wire
